// >>> sdsc_switch_ctrl.sv
// Send Byte bus slave driving two switch enables, with power-on and overheat gating
`timescale 1ns/1ps
module sdsc_switch_ctrl #(
  parameter int POR_CYCLES = sdsc_pkg::POR_CYCLES,
  parameter int UV_CYCLES = sdsc_pkg::UV_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select_pin,
  input wire logic undervoltage,
  input wire logic overheat,
  output logic switch_a_output,
  output logic switch_b_output
);
  localparam int CW = $clog2(POR_CYCLES + UV_CYCLES + 1);

  // Link domain
  logic [4:0] link_flt;
  sdsc_pkg::sdsc_bus_t bus_now;
  sdsc_pkg::sdsc_bus_t bus_prev;
  logic por_link;
  logic [1:0] sel_f;
  sdsc_pkg::sdsc_state_t state;
  sdsc_pkg::sdsc_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic ack_on;
  logic next_ack_on;
  logic pending;
  logic next_pending;
  sdsc_pkg::sdsc_cmd_t cmd_hold;
  sdsc_pkg::sdsc_cmd_t next_cmd_hold;
  logic commit_tgl;
  logic next_commit_tgl;

  // System domain
  logic [4:0] sys_flt;
  logic uv_f;
  logic ovh_f;
  logic commit_sync;
  sdsc_pkg::sdsc_cmd_t cmd_sync;
  logic commit_seen;
  logic commit_pulse;
  logic por_busy;
  logic next_por_busy;
  logic [CW-1:0] por_cnt;
  logic [CW-1:0] next_por_cnt;
  logic [CW-1:0] uv_cnt;
  logic [CW-1:0] next_uv_cnt;
  logic por_done;
  logic uv_trip;
  sdsc_pkg::sdsc_cmd_t out_latch;
  sdsc_pkg::sdsc_cmd_t next_latch;
  sdsc_pkg::sdsc_cmd_t next_sw;

  // Pins and the power gate enter the link domain through three stages
  sdsc_sync #(
    .WIDTH(5),
    .INIT(sdsc_pkg::LINK_SYNC_INIT)
  ) u_link_sync (
    .clock(link_clock),
    .rstn(rstn),
    .async_in({scl_in, sda_in, por_busy, addr_select_pin}),
    .sync_out(link_flt)
  );

  assign bus_now = sdsc_pkg::sdsc_bus_t'(link_flt[4:3]);
  assign por_link = link_flt[2];
  assign sel_f = link_flt[1:0];

  wire scl_rise = bus_now.scl && !bus_prev.scl;
  wire scl_fall = !bus_now.scl && bus_prev.scl;
  wire scl_held = bus_now.scl && bus_prev.scl;
  wire start_cond = scl_held && bus_prev.sda && !bus_now.sda;
  wire stop_cond = scl_held && !bus_prev.sda && bus_now.sda;
  wire in_byte = (state == sdsc_pkg::ST_ADDR) || (state == sdsc_pkg::ST_CMD);
  wire in_ack = (state == sdsc_pkg::ST_ACK_ADDR) || (state == sdsc_pkg::ST_ACK_CMD);
  wire abort = por_link || start_cond || stop_cond;
  wire mid_byte = in_byte && (bit_cnt != 3'h0);
  wire shifting = in_byte && scl_rise && !por_link;
  wire last_bit = scl_rise && (bit_cnt == sdsc_pkg::LAST_BIT);
  wire [6:0] own_addr = sdsc_pkg::sdsc_addr(sel_f);
  // Eighth bit is sampled live: low asks for a write
  wire addr_hit = (shift[6:0] == own_addr) && !bus_now.sda;
  wire ack_end = in_ack && scl_fall && ack_on;
  wire capture = (state == sdsc_pkg::ST_ACK_CMD) && ack_end && !por_link;
  wire commit_go = stop_cond && pending && (state == sdsc_pkg::ST_WAIT_STOP) && !por_link;

  always_comb begin
    next_state = state;
    if (por_link) begin
      next_state = sdsc_pkg::ST_IDLE;
    end else if (start_cond) begin
      next_state = sdsc_pkg::ST_ADDR;
    end else if (stop_cond) begin
      next_state = sdsc_pkg::ST_IDLE;
    end else begin
      case (state)
        sdsc_pkg::ST_ADDR: begin
          if (last_bit) begin
            next_state = addr_hit ? sdsc_pkg::ST_ACK_ADDR : sdsc_pkg::ST_IDLE;
          end
        end
        sdsc_pkg::ST_ACK_ADDR: begin
          if (ack_end) begin
            next_state = sdsc_pkg::ST_CMD;
          end
        end
        sdsc_pkg::ST_CMD: begin
          if (last_bit) begin
            next_state = sdsc_pkg::ST_ACK_CMD;
          end
        end
        sdsc_pkg::ST_ACK_CMD: begin
          if (ack_end) begin
            next_state = sdsc_pkg::ST_WAIT_STOP;
          end
        end
        sdsc_pkg::ST_IDLE: begin
          next_state = sdsc_pkg::ST_IDLE;
        end
        sdsc_pkg::ST_WAIT_STOP: begin
          next_state = sdsc_pkg::ST_WAIT_STOP;
        end
        default: begin
          next_state = sdsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign next_bit_cnt = abort ? 3'h0 : shifting ? bit_cnt + 3'h1 : in_byte ? bit_cnt : 3'h0;
  assign next_shift = shifting ? {shift[6:0], bus_now.sda} : shift;
  // Pull low from the fall after the eighth bit to the fall after the ninth
  assign next_ack_on = (in_ack && !abort) ? (scl_fall ? !ack_on : ack_on) : 1'b0;
  assign next_cmd_hold = capture ? sdsc_pkg::sdsc_cmd_t'(shift[1:0]) : cmd_hold;
  assign next_pending = abort ? 1'b0 : capture ? 1'b1 : pending;
  assign next_commit_tgl = commit_go ? !commit_tgl : commit_tgl;

  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      bus_prev <= '{scl: 1'b1, sda: 1'b1};
      state <= sdsc_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      ack_on <= 1'b0;
    end else begin
      bus_prev <= bus_now;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      ack_on <= next_ack_on;
    end
  end

  // Held word stays still from acknowledge until Stop, long before it is read
  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
      cmd_hold <= sdsc_pkg::SWITCH_RESET;
      commit_tgl <= 1'b0;
    end else begin
      pending <= next_pending;
      cmd_hold <= next_cmd_hold;
      commit_tgl <= next_commit_tgl;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = ack_on;

  // System side
  sdsc_sync #(
    .WIDTH(5),
    .INIT(sdsc_pkg::SYS_SYNC_INIT)
  ) u_sys_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({commit_tgl, cmd_hold, undervoltage, overheat}),
    .sync_out(sys_flt)
  );

  assign commit_sync = sys_flt[4];
  assign cmd_sync = sdsc_pkg::sdsc_cmd_t'(sys_flt[3:2]);
  assign uv_f = sys_flt[1];
  assign ovh_f = sys_flt[0];
  assign commit_pulse = commit_sync ^ commit_seen;

  assign por_done = por_cnt == CW'(POR_CYCLES - 1);
  assign uv_trip = uv_cnt == CW'(UV_CYCLES - 1);

  // Any undervoltage during the delay restarts it
  assign next_por_cnt = (!por_busy || uv_f || por_done) ? '0 : por_cnt + CW'(1);
  // Dips shorter than the filter reset the count and are forgotten
  assign next_uv_cnt = (por_busy || !uv_f || uv_trip) ? '0 : uv_cnt + CW'(1);
  assign next_por_busy = por_busy ? !(por_done && !uv_f) : (uv_f && uv_trip);

  assign next_latch = por_busy ? sdsc_pkg::SWITCH_RESET : commit_pulse ? cmd_sync : out_latch;
  // Latch is not touched by overheat so it resumes afterwards
  assign next_sw = ovh_f ? sdsc_pkg::SWITCH_RESET : out_latch;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      por_busy <= 1'b1;
      por_cnt <= '0;
      uv_cnt <= '0;
      commit_seen <= 1'b0;
    end else begin
      por_busy <= next_por_busy;
      por_cnt <= next_por_cnt;
      uv_cnt <= next_uv_cnt;
      commit_seen <= commit_sync;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_latch <= sdsc_pkg::SWITCH_RESET;
      switch_a_output <= 1'b0;
      switch_b_output <= 1'b0;
    end else begin
      out_latch <= next_latch;
      switch_a_output <= next_sw.switch_a;
      switch_b_output <= next_sw.switch_b;
    end
  end

  // Checks: link domain
  sequence s_addr_last;
    state == sdsc_pkg::ST_ADDR && last_bit && !por_link;
  endsequence

  sequence s_ack_open;
    in_ack && scl_fall && !ack_on && !por_link;
  endsequence

  property p_read_ignored;
    @(posedge link_clock) disable iff (!rstn)
      s_addr_last ##0 bus_now.sda |=> state == sdsc_pkg::ST_IDLE && !sda_oe;
  endproperty
  a_read_ignored: assert property (p_read_ignored) else $error("read request not ignored");

  property p_addr_miss;
    @(posedge link_clock) disable iff (!rstn)
      s_addr_last ##0 (shift[6:0] != own_addr) |=> state == sdsc_pkg::ST_IDLE ##1 !sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("mismatch did not return idle");

  // Select code 2'b11 falls back to the low address
  property p_addr_match;
    @(posedge link_clock) disable iff (!rstn)
      s_addr_last ##0 (!bus_now.sda
        && shift[6:0] == {sdsc_pkg::ADDR_FIXED, sel_f[1] && !sel_f[0], sel_f[0] && !sel_f[1]})
      |=> state == sdsc_pkg::ST_ACK_ADDR;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("own write address not taken");

  property p_addr_ack;
    @(posedge link_clock) disable iff (!rstn)
      s_ack_open ##0 state == sdsc_pkg::ST_ACK_ADDR |=> sda_oe && state == sdsc_pkg::ST_ACK_ADDR;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge missing");

  property p_cmd_ack;
    @(posedge link_clock) disable iff (!rstn)
      s_ack_open ##0 state == sdsc_pkg::ST_ACK_CMD |=> sda_oe;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command acknowledge missing");

  property p_ack_release;
    @(posedge link_clock) disable iff (!rstn)
      ack_end |=> !sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge held past ninth clock");

  property p_oe_in_ack;
    @(posedge link_clock) disable iff (!rstn)
      sda_oe |-> $past(in_ack);
  endproperty
  a_oe_in_ack: assert property (p_oe_in_ack) else $error("data driven outside acknowledge");

  property p_mid_error;
    @(posedge link_clock) disable iff (!rstn)
      (start_cond || stop_cond) && mid_byte |=> !pending && bit_cnt == 3'h0 && $stable(commit_tgl);
  endproperty
  a_mid_error: assert property (p_mid_error) else $error("mid-byte condition not discarded");

  property p_capture;
    @(posedge link_clock) disable iff (!rstn)
      capture |=> pending && cmd_hold.switch_a == shift[0] && cmd_hold.switch_b == shift[1];
  endproperty
  a_capture: assert property (p_capture) else $error("command not held at acknowledge");

  property p_commit;
    @(posedge link_clock) disable iff (!rstn)
      commit_go |=> commit_tgl != $past(commit_tgl) && !pending;
  endproperty
  a_commit: assert property (p_commit) else $error("stop did not commit");

  // Checks: system domain
  property p_latch_only_commit;
    @(posedge clock) disable iff (!rstn)
      $changed(out_latch) |-> $past(commit_pulse) || $past(por_busy);
  endproperty
  a_latch_only_commit: assert property (p_latch_only_commit) else $error("latch moved without stop");

  property p_por_off;
    @(posedge clock) disable iff (!rstn)
      por_busy ##1 por_busy |=> !switch_a_output && !switch_b_output;
  endproperty
  a_por_off: assert property (p_por_off) else $error("switch on during power-on reset");

  property p_por_release;
    @(posedge clock) disable iff (!rstn)
      por_busy && !uv_f && por_cnt != CW'(POR_CYCLES - 1) |=> por_busy;
  endproperty
  a_por_release: assert property (p_por_release) else $error("power-on reset ended early");

  property p_uv_trip;
    @(posedge clock) disable iff (!rstn)
      !por_busy && !uv_f |=> !por_busy;
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("short dip restarted power-on reset");

  property p_overheat;
    @(posedge clock) disable iff (!rstn)
      ovh_f |=> !switch_a_output && !switch_b_output;
  endproperty
  a_overheat: assert property (p_overheat) else $error("switch on during overheat");

  property p_resume;
    @(posedge clock) disable iff (!rstn)
      !ovh_f |=> {switch_b_output, switch_a_output} == $past(out_latch);
  endproperty
  a_resume: assert property (p_resume) else $error("outputs do not follow latch");
endmodule : sdsc_switch_ctrl

// >>> sdsc_sync.sv
// Shared constants, types and the three-stage input synchroniser
`timescale 1ns/1ps
package sdsc_pkg;
  localparam int CLOCK_MHZ = 100;
  localparam int POR_TIME_US = 300;
  localparam int UV_TIME_US = 100;
  localparam int POR_CYCLES = POR_TIME_US * CLOCK_MHZ;
  localparam int UV_CYCLES = UV_TIME_US * CLOCK_MHZ;
  localparam logic [4:0] ADDR_FIXED = 5'h16;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] SWITCH_RESET = 2'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] LINK_SYNC_INIT = 5'h1C;
  localparam logic [4:0] SYS_SYNC_INIT = 5'h00;

  typedef struct packed {
    logic scl;
    logic sda;
  } sdsc_bus_t;

  typedef struct packed {
    logic switch_b;
    logic switch_a;
  } sdsc_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK_ADDR = 6'h04,
    ST_CMD = 6'h08,
    ST_ACK_CMD = 6'h10,
    ST_WAIT_STOP = 6'h20
  } sdsc_state_t;

  // Select pin 2'b11 is not a legal level; it falls back to the low address
  function automatic logic [6:0] sdsc_addr(input logic [1:0] sel);
    logic [1:0] low;
    low = (sel == SEL_HIGH) ? 2'h2 : (sel == SEL_MID) ? 2'h1 : 2'h0;
    return {ADDR_FIXED, low};
  endfunction : sdsc_addr
endpackage : sdsc_pkg

module sdsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_out;

  // A bit moves only when stages two and three agree
  assign next_out = (stage2 & stage3) | (sync_out & (stage2 | stage3));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_out;
    end
  end
endmodule : sdsc_sync

// >>> sdsc_host_model.sv
// Bus host model issuing Send Byte transfers, paced by the link clock
`timescale 1ns/1ps
module sdsc_host_model (
  input wire logic link_clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // Idle bus: both lines released to the pull-ups, clock stands still
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic wait_lc(input int n);
    repeat (n) @(posedge link_clock);
    #1;
  endtask : wait_lc

  // Also usable mid-byte, where it forms a repeated Start
  task automatic bus_start();
    wait_lc(6);
    sda = 1'b1;
    wait_lc(6);
    scl = 1'b1;
    wait_lc(12);
    sda = 1'b0;
    wait_lc(12);
    scl = 1'b0;
  endtask : bus_start

  task automatic put_bit(input logic b);
    wait_lc(6);
    sda = b;
    wait_lc(6);
    scl = 1'b1;
    wait_lc(12);
    scl = 1'b0;
  endtask : put_bit

  task automatic get_ack(output logic ack);
    wait_lc(6);
    sda = 1'b1;
    wait_lc(6);
    scl = 1'b1;
    ack = ~sda_line;
    wait_lc(12);
    scl = 1'b0;
  endtask : get_ack

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_ack(ack);
  endtask : send_byte

  task automatic bus_stop();
    wait_lc(6);
    sda = 1'b0;
    wait_lc(6);
    scl = 1'b1;
    wait_lc(12);
    sda = 1'b1;
    wait_lc(12);
  endtask : bus_stop
endmodule : sdsc_host_model

// >>> sdsc_switch_ctrl_tb.sv
// Self-checking testbench for the Send Byte switch controller
`timescale 1ns/1ps
module sdsc_switch_ctrl_tb;
  localparam int POR_SIM = 50;
  localparam int UV_SIM = 20;
  logic clock, rstn, link_clock, sda_out, sda_oe, undervoltage, overheat, sw_a, sw_b;
  logic host_scl, host_sda, sda_line;
  logic [1:0] addr_select_pin;
  logic [1:0] exp_sw;
  int fails, checks;

  // Open-drain wire: low if either party pulls
  assign sda_line = host_sda & ~(sda_oe & ~sda_out);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #3.3;
    forever #7.5 link_clock = ~link_clock;
  end

  sdsc_switch_ctrl #(.POR_CYCLES(POR_SIM), .UV_CYCLES(UV_SIM)) i_dut (
    .clock(clock), .rstn(rstn), .link_clock(link_clock), .scl_in(host_scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .undervoltage(undervoltage),
    .overheat(overheat), .switch_a_output(sw_a), .switch_b_output(sw_b)
  );
  sdsc_host_model i_host (.link_clock(link_clock), .sda_line(sda_line), .scl(host_scl), .sda(host_sda));

  function automatic logic [6:0] want_addr(input logic [1:0] sel);
    return (sel == 2'h2) ? 7'h5a : (sel == 2'h1) ? 7'h59 : 7'h58;
  endfunction : want_addr

  task automatic test_done();
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t ack got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_sw(input logic [1:0] exp);
    checks++;
    if ({sw_b, sw_a} !== exp) begin
      fails++;
      $display("[ERR] %0t switches got %h exp %h", $time, {sw_b, sw_a}, exp);
    end
  endtask : cmp_sw

  task automatic clk_wait(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : clk_wait

  // Outputs are checked still old just before Stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic ack_a, input logic ack_c);
    logic k;
    i_host.bus_start();
    i_host.send_byte(a, k);
    cmp_bit(k, ack_a);
    i_host.send_byte(c, k);
    cmp_bit(k, ack_c);
    cmp_sw(exp_sw);
    i_host.bus_stop();
    clk_wait(30);
  endtask : xfer

  initial begin
    #800_000;
    fails++;
    test_done();
  end

  initial begin
    logic [7:0] c;
    logic [1:0] s;
    logic k;
    rstn = 1'b0;
    undervoltage = 1'b0;
    overheat = 1'b0;
    addr_select_pin = 2'h0;
    fails = 0;
    checks = 0;
    exp_sw = 2'h0;
    void'($urandom(32'h95ac_14a1));
    clk_wait(12);
    rstn = 1'b1;
    clk_wait(POR_SIM + 20);
    cmp_sw(2'h0);
    for (int i = 0; i < 6; i++) begin
      s = 2'(i % 3);
      c = (i == 0) ? 8'hfd : 8'($urandom);
      addr_select_pin = s;
      xfer({want_addr(s), 1'b0}, c, 1'b1, 1'b1);
      exp_sw = c[1:0];
      cmp_sw(exp_sw);
      xfer({want_addr(s), 1'b1}, ~c, 1'b0, 1'b0);
      cmp_sw(exp_sw);
      xfer({want_addr(s) ^ (7'h01 << (i % 7)), 1'b0}, ~c, 1'b0, 1'b0);
      cmp_sw(exp_sw);
      // Cut the command byte short by Stop on even passes, by a repeated Start ahead of the Stop on odd ones
      i_host.bus_start();
      i_host.send_byte({want_addr(s), 1'b0}, k);
      cmp_bit(k, 1'b1);
      for (int j = 0; j < 3; j++) begin
        i_host.put_bit(~exp_sw[j % 2]);
      end
      if (i % 2 == 1) begin
        i_host.bus_start();
      end
      i_host.bus_stop();
      clk_wait(30);
      cmp_sw(exp_sw);
    end
    // Unused select code answers on the low address
    addr_select_pin = 2'h3;
    xfer({want_addr(2'h3), 1'b0}, 8'h03, 1'b1, 1'b1);
    exp_sw = 2'h3;
    cmp_sw(exp_sw);
    addr_select_pin = s;
    overheat = 1'b1;
    clk_wait(20);
    exp_sw = 2'h0;
    cmp_sw(exp_sw);
    xfer({want_addr(s), 1'b0}, 8'h01, 1'b1, 1'b1);
    cmp_sw(exp_sw);
    overheat = 1'b0;
    clk_wait(20);
    exp_sw = 2'h1;
    cmp_sw(exp_sw);
    // Dip shorter than the filter must not clear the latch
    undervoltage = 1'b1;
    clk_wait(UV_SIM / 2);
    undervoltage = 1'b0;
    clk_wait(POR_SIM * 2);
    cmp_sw(exp_sw);
    undervoltage = 1'b1;
    clk_wait(UV_SIM * 2);
    exp_sw = 2'h0;
    cmp_sw(exp_sw);
    xfer({want_addr(s), 1'b0}, 8'h03, 1'b0, 1'b0);
    undervoltage = 1'b0;
    clk_wait(POR_SIM / 2);
    cmp_sw(exp_sw);
    clk_wait(POR_SIM);
    xfer({want_addr(s), 1'b0}, 8'h02, 1'b1, 1'b1);
    exp_sw = 2'h2;
    cmp_sw(exp_sw);
    test_done();
  end
endmodule : sdsc_switch_ctrl_tb
